// ==== verilog/pcg_pkg.sv ====
// Purpose: constants and bus carriers for the peripheral clock gate block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   offsets and the status register layout are local choices
package pcg_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CLK_EN_ONE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RST_CTL_ONE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CLK_EN_TWO  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GATE_STATUS = 8'h0c;

  // Field positions shared by enable, reset and status words
  localparam int BASE_LSB  = 0;
  localparam int TIMER_LSB = 8;
  localparam int QUAD_LSB  = 16;
  localparam int CAN_LSB   = 4;
  localparam int UNITS     = 4;
  localparam int CAN_W     = 3;

  // Writable bits
  localparam logic [31:0] MASK_CLK_EN_ONE  = 32'h000f_0f0f;
  localparam logic [31:0] MASK_RST_CTL_ONE = 32'h000f_0f0f;
  localparam logic [31:0] MASK_CLK_EN_TWO  = 32'h1333_f103;
  localparam logic [31:0] MASK_CAN_FIELD   = 32'h0000_0070;

  // Values after reset
  localparam logic [31:0] RST_CLK_EN_ONE   = 32'h000f_0f0f;
  localparam logic [31:0] RST_RST_CTL_ONE  = 32'h0000_0000;
  localparam logic [31:0] RST_CLK_EN_TWO   = 32'h0313_f000;
  localparam logic [31:0] RST_CAN_FIELD    = 32'h0000_0070;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pcg_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcg_axil_rsp_s;

  typedef struct packed {
    logic [UNITS-1:0] quad;
    logic [UNITS-1:0] timer;
    logic [UNITS-1:0] base;
  } pcg_unit_set_s;

endpackage

// ==== verilog/pcg_clock_reset.sv ====
// Purpose: peripheral clock gating and software reset for timer units
// Assumes: core_clk is the bus clock; srst synchronous, active high
// Notes:   clock gates switch on the low phase so gated clocks never glitch
//
// How it works
// - enable bits 8..11 gate timer unit groups
// - timer enable 1 delivers bus clock
// - timer enable 0 stops its bus clock
// - timer enables read 1 after reset
// - enable bits 0..3 gate base timer groups
// - base enable 1 supplies, 0 gates clock
// - base timer enables read 1 after reset
// - reset bits 16..19 reset quad counters
// - quad reset bit 1 holds unit reset
// - reset bits 8..11 reset timer units
// - timer reset bit 1 holds unit reset
// - reset bits 0..3 reset base groups
// - base reset bit 1 holds group reset
// - all reset bits read 0 after reset
// - reset persists until software writes 0
// - without CAN, CAN field reads-only 000
// - quad enable 0 gates, 1 supplies clock
`timescale 1ns/1ps

module pcg_clock_reset #(
  parameter bit CAN_PRESENT = 1'b1
) (
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  input  wire logic                   clk_en,
  input  wire pcg_pkg::pcg_axil_req_s axil_req,
  output pcg_pkg::pcg_axil_rsp_s      axil_rsp,
  output logic [3:0]                  timer_unit_clk,
  output logic [3:0]                  base_timer_clk,
  output logic [3:0]                  quad_counter_clk,
  output logic [2:0]                  can_clk,
  output logic [31:0]                 clk_en_two_state,
  output logic [3:0]                  timer_unit_reset_bits,
  output logic [3:0]                  base_timer_reset_bits,
  output logic [3:0]                  quad_counter_reset_bits
);
  import pcg_pkg::*;

  localparam logic [31:0] MASK_TWO = CAN_PRESENT ?
    (MASK_CLK_EN_TWO | MASK_CAN_FIELD) : MASK_CLK_EN_TWO;
  localparam logic [31:0] RST_TWO = CAN_PRESENT ?
    (RST_CLK_EN_TWO | RST_CAN_FIELD) : RST_CLK_EN_TWO;

  // Byte-lane merge limited to writable bits; reserved bits stay zero
  function automatic logic [31:0] merge_write(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    lanes = lanes & mask;
    merge_write = (old_val & ~lanes) | (new_val & lanes);
  endfunction

  function automatic pcg_unit_set_s unit_fields(input logic [31:0] word);
    unit_fields.quad  = word[QUAD_LSB +: UNITS];
    unit_fields.timer = word[TIMER_LSB +: UNITS];
    unit_fields.base  = word[BASE_LSB +: UNITS];
  endfunction

  logic [31:0]       clk_en_one;
  logic [31:0]       rst_ctl_one;
  logic [31:0]       clk_en_two;
  pcg_unit_set_s     gate_on;
  logic [CAN_W-1:0]  can_gate_on;

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  // Bus handshakes are only taken while the block is clocked
  wire               aw_hs = clk_en & axil_req.awvalid & axil_rsp.awready;
  wire               w_hs  = clk_en & axil_req.wvalid & axil_rsp.wready;
  wire               ar_hs = clk_en & axil_req.arvalid & axil_rsp.arready;
  wire               have_aw = aw_held | aw_hs;
  wire               have_w  = w_held | w_hs;
  wire               do_write = have_aw & have_w;
  wire [ADDR_W-1:0]  wr_addr = aw_held ? aw_addr : axil_req.awaddr;
  wire [31:0]        wr_data = w_held ? w_data : axil_req.wdata;
  wire [3:0]         wr_strb = w_held ? w_strb : axil_req.wstrb;

  wire               wr_one = do_write & (wr_addr == OFS_CLK_EN_ONE);
  wire               wr_rst = do_write & (wr_addr == OFS_RST_CTL_ONE);
  wire               wr_two = do_write & (wr_addr == OFS_CLK_EN_TWO);
  wire               wr_hit = wr_one | wr_rst | wr_two;

  wire               next_bvalid = do_write |
                                   (axil_rsp.bvalid & ~axil_req.bready);
  wire               next_aw_held = have_aw & ~have_w;
  wire               next_w_held  = have_w & ~have_aw;
  wire               next_rvalid  = ar_hs |
                                   (axil_rsp.rvalid & ~axil_req.rready);

  // Read decode
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    if (axil_req.araddr == OFS_CLK_EN_ONE) begin
      rd_word = clk_en_one;
    end else if (axil_req.araddr == OFS_RST_CTL_ONE) begin
      rd_word = rst_ctl_one;
    end else if (axil_req.araddr == OFS_CLK_EN_TWO) begin
      rd_word = clk_en_two;
    end else if (axil_req.araddr == OFS_GATE_STATUS) begin
      // Gate state as actually applied, one half cycle behind the enables
      rd_word = '0;
      rd_word[QUAD_LSB +: UNITS]  = gate_on.quad;
      rd_word[TIMER_LSB +: UNITS] = gate_on.timer;
      rd_word[BASE_LSB +: UNITS]  = gate_on.base;
      rd_word[CAN_LSB +: CAN_W]   = can_gate_on;
    end else begin
      rd_word = '0;
      rd_hit  = 1'b0;
    end
  end

  // Write channel bookkeeping
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else if (clk_en) begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      if (aw_hs) begin
        aw_addr <= axil_req.awaddr;
      end
      if (w_hs) begin
        w_data <= axil_req.wdata;
        w_strb <= axil_req.wstrb;
      end
    end
  end

  // Bus answer flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      axil_rsp <= '0;
    end else if (clk_en) begin
      axil_rsp.awready <= ~next_aw_held & ~next_bvalid;
      axil_rsp.wready  <= ~next_w_held & ~next_bvalid;
      axil_rsp.bvalid  <= next_bvalid;
      axil_rsp.arready <= ~next_rvalid;
      axil_rsp.rvalid  <= next_rvalid;
      if (do_write) begin
        axil_rsp.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_hs) begin
        axil_rsp.rdata <= rd_word;
        axil_rsp.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Control registers; reserved bits masked on write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clk_en_one  <= RST_CLK_EN_ONE;
      rst_ctl_one <= RST_RST_CTL_ONE;
      clk_en_two  <= RST_TWO;
    end else if (clk_en) begin
      if (wr_one) begin
        clk_en_one <= merge_write(clk_en_one, wr_data, wr_strb,
                                  MASK_CLK_EN_ONE);
      end
      // A reset bit only clears by an explicit write of 0
      if (wr_rst) begin
        rst_ctl_one <= merge_write(rst_ctl_one, wr_data, wr_strb,
                                   MASK_RST_CTL_ONE);
      end
      // Without CAN the field is absent from the mask, so it stays 000
      if (wr_two) begin
        clk_en_two <= merge_write(clk_en_two, wr_data, wr_strb,
                                  MASK_TWO);
      end
    end
  end

  // Gate enables sampled on the falling edge: the AND below can only
  // change while core_clk is low, so no runt pulse can escape.
  always_ff @(negedge core_clk) begin
    if (srst) begin
      gate_on     <= unit_fields(RST_CLK_EN_ONE);
      can_gate_on <= RST_TWO[CAN_LSB +: CAN_W];
    end else if (clk_en) begin
      gate_on     <= unit_fields(clk_en_one);
      can_gate_on <= clk_en_two[CAN_LSB +: CAN_W];
    end
  end

  // Gated bus clocks for each unit group
  assign timer_unit_clk   = {UNITS{core_clk}} & gate_on.timer;
  assign base_timer_clk   = {UNITS{core_clk}} & gate_on.base;
  assign quad_counter_clk = {UNITS{core_clk}} & gate_on.quad;
  assign can_clk          = {CAN_W{core_clk}} & can_gate_on;

  // Reset outputs held while the matching bit stays set
  always_ff @(posedge core_clk) begin
    if (srst) begin
      quad_counter_reset_bits <= '0;
      timer_unit_reset_bits   <= '0;
      base_timer_reset_bits   <= '0;
      clk_en_two_state        <= RST_TWO;
    end else if (clk_en) begin
      quad_counter_reset_bits <= rst_ctl_one[QUAD_LSB +: UNITS];
      timer_unit_reset_bits   <= rst_ctl_one[TIMER_LSB +: UNITS];
      base_timer_reset_bits   <= rst_ctl_one[BASE_LSB +: UNITS];
      clk_en_two_state        <= clk_en_two;
    end
  end

endmodule

// ==== tb/pcg_clock_reset_properties.sv ====
// Purpose: port-level checks for pcg_clock_reset
// Assumes: sees top ports only; all four write lanes in reset writes
// Notes:   gated clocks judged at rising edges, where they must be low
`timescale 1ns/1ps
module pcg_props (
  input wire logic                   core_clk,
  input wire logic                   srst,
  input wire logic                   clk_en,
  input wire pcg_pkg::pcg_axil_req_s axil_req,
  input wire pcg_pkg::pcg_axil_rsp_s axil_rsp,
  input wire logic [3:0]             timer_unit_clk,
  input wire logic [3:0]             base_timer_clk,
  input wire logic [3:0]             quad_counter_clk,
  input wire logic [3:0]             timer_unit_reset_bits,
  input wire logic [3:0]             base_timer_reset_bits,
  input wire logic [3:0]             quad_counter_reset_bits
);
  import pcg_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire        wr_go  = clk_en && axil_req.awvalid && axil_rsp.awready
                       && axil_req.wvalid && axil_rsp.wready;
  wire        wr_rst = wr_go && axil_req.awaddr == OFS_RST_CTL_ONE;
  wire [11:0] rbits  = {quad_counter_reset_bits, timer_unit_reset_bits,
                        base_timer_reset_bits};
  property p_wr_ans;
    wr_go |=> axil_rsp.bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_rd_ans;
    clk_en && axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_b_hold;
    axil_rsp.bvalid && !(clk_en && axil_req.bready)
      |=> axil_rsp.bvalid && $stable(axil_rsp.bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    axil_rsp.rvalid && !(clk_en && axil_req.rready)
      |=> axil_rsp.rvalid && $stable(axil_rsp.rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_freeze;
    !clk_en |=> $stable(axil_rsp);
  endproperty
  a_freeze: assert property (p_freeze) else $error("bus moved while frozen");
  property p_rst_set;
    wr_rst && axil_req.wstrb == 4'hf ##1 clk_en |=> rbits ==
      {$past(axil_req.wdata[19:16], 2), $past(axil_req.wdata[11:8], 2),
       $past(axil_req.wdata[3:0], 2)};
  endproperty
  a_rst_set: assert property (p_rst_set) else $error("reset bits wrong");
  property p_rst_hold;
    $changed(rbits) |-> $past(wr_rst, 2);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset bits moved");
  property p_rst_init;
    $fell(srst) |-> rbits == 12'h0;
  endproperty
  a_rst_init: assert property (p_rst_init) else $error("reset bits not 0");
  property p_glitch;
    {timer_unit_clk, base_timer_clk, quad_counter_clk} == 12'h0;
  endproperty
  a_glitch: assert property (p_glitch) else $error("gated clock high");
endmodule
bind pcg_clock_reset pcg_props u_props (.core_clk, .srst, .clk_en,
  .axil_req, .axil_rsp, .timer_unit_clk, .base_timer_clk,
  .quad_counter_clk, .timer_unit_reset_bits, .base_timer_reset_bits,
  .quad_counter_reset_bits);

// ==== tb/pcg_clock_reset_tb.sv ====
// Purpose: self-checking bench for pcg_clock_reset
// Assumes: default CAN_PRESENT; every write uses all byte lanes
// Notes:   bus results queued by the driver, compared by a monitor
`timescale 1ns/1ps
module pcg_clock_reset_tb;
  import pcg_pkg::*;
  logic          core_clk;
  logic          srst;
  logic          clk_en;
  pcg_axil_req_s req;
  pcg_axil_rsp_s rsp;
  logic [3:0]    tclk, bclk, qclk, trst, brst, qrst;
  logic [2:0]    cclk;
  logic [31:0]   cen2, v;
  logic [33:0]   exp_q[$];
  int            num_errors, total_checks;
  logic [15:0]   rnd;
  pcg_clock_reset dut_u (.core_clk, .srst, .clk_en, .axil_req(req),
    .axil_rsp(rsp), .timer_unit_clk(tclk), .base_timer_clk(bclk),
    .quad_counter_clk(qclk), .can_clk(cclk), .clk_en_two_state(cen2),
    .timer_unit_reset_bits(trst), .base_timer_reset_bits(brst),
    .quad_counter_reset_bits(qrst));
  task automatic check(input string nm, input logic [33:0] e, a);
    total_checks++;
    if (a !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, a);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Sampled mid-cycle, so each handshake is seen exactly once
  always @(negedge core_clk) begin
    if (clk_en && rsp.rvalid && req.rready)
      check("read", exp_q.pop_front(), {rsp.rresp, rsp.rdata});
    if (clk_en && rsp.bvalid && req.bready)
      check("write", exp_q.pop_front(), {rsp.bresp, 32'h0});
  end
  task automatic xfer(input bit w, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] r);
    bit aw, wd, ar, done;
    @(posedge core_clk);
    exp_q.push_back(w ? {r, 32'h0} : {r, d});
    req.awvalid <= w;
    req.wvalid <= w;
    req.bready <= w;
    req.arvalid <= !w;
    req.rready <= !w;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge core_clk);
      aw = clk_en && req.awvalid && rsp.awready;
      wd = clk_en && req.wvalid && rsp.wready;
      ar = clk_en && req.arvalid && rsp.arready;
      done = clk_en && (w ? rsp.bvalid : rsp.rvalid);
      @(posedge core_clk);
      if (aw) req.awvalid <= 1'b0;
      if (wd) req.wvalid <= 1'b0;
      if (ar) req.arvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    if (!done) begin
      num_errors++;
      print_verdict();
    end
  endtask
  // Judged in the high phase, when a running gated clock is high
  task automatic lvl(input logic [11:0] g, input logic [11:0] rb);
    repeat (3) @(posedge core_clk);
    #5;
    check("gates", {22'h0, g}, {22'h0, qclk, tclk, bclk});
    check("resets", {22'h0, rb}, {22'h0, qrst, trst, brst});
    check("two", {2'h0, RST_CLK_EN_TWO | RST_CAN_FIELD}, {2'h0, cen2});
    check("can", 34'h7, {31'h0, cclk});
  endtask
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    req = '0;
    rnd = 16'hb501;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    xfer(0, OFS_CLK_EN_ONE, RST_CLK_EN_ONE, RESP_OKAY);
    xfer(0, OFS_RST_CTL_ONE, 32'h0, RESP_OKAY);
    xfer(0, OFS_CLK_EN_TWO, RST_CLK_EN_TWO | RST_CAN_FIELD, RESP_OKAY);
    lvl(12'hfff, 12'h0);
    for (int i = 0; i < 4; i++) begin
      v = RST_CLK_EN_ONE & ~(32'h0001_0101 << i);
      xfer(1, OFS_CLK_EN_ONE, v, RESP_OKAY);
      xfer(0, OFS_CLK_EN_ONE, v, RESP_OKAY);
      lvl({v[19:16], v[11:8], v[3:0]}, 12'h0);
    end
    xfer(1, OFS_CLK_EN_ONE, RST_CLK_EN_ONE, RESP_OKAY);
    lvl(12'hfff, 12'h0);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      v = {12'h0, rnd[11:8], 4'h0, rnd[7:4], 4'h0, rnd[3:0]};
      xfer(1, OFS_RST_CTL_ONE, v, RESP_OKAY);
      clk_en <= 1'b0;
      repeat (4) @(posedge core_clk);
      clk_en <= 1'b1;
      xfer(0, OFS_RST_CTL_ONE, v, RESP_OKAY);
      lvl(12'hfff, {v[19:16], v[11:8], v[3:0]});
    end
    xfer(1, OFS_RST_CTL_ONE, 32'h0, RESP_OKAY);
    lvl(12'hfff, 12'h0);
    xfer(0, OFS_GATE_STATUS, RST_CLK_EN_ONE | RST_CAN_FIELD, RESP_OKAY);
    xfer(1, 8'h10, 32'hffff_ffff, RESP_SLVERR);
    xfer(0, 8'h10, 32'h0, RESP_SLVERR);
    xfer(1, OFS_GATE_STATUS, 32'h0, RESP_SLVERR);
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
endmodule
